// >>> hw/cocr_pkg.sv
// Package: constants of the second charger configuration register block
package cocr_pkg;

  // Core clock rate
  localparam longint unsigned CLK_HZ = 64'd40_000_000;

  // Register command address and layout
  localparam logic [7:0] CFG2_ADDR = 8'h30;
  localparam logic [15:0] CFG2_RESET = 16'h0211;
  localparam logic [7:0] LOWPWR_MODE_REG_ADDR = 8'h12;
  localparam int LOWPWR_MODE_BIT = 15;

  // Field positions
  localparam int BATT_MON_EN_BIT = 15;
  localparam int ALERT_SEL_HI = 14;
  localparam int ALERT_SEL_LO = 13;
  localparam int SYS_PWR_EN_BIT = 12;
  localparam int IN_SHUNT_BIT = 11;
  localparam int CHG_SHUNT_BIT = 10;
  localparam int PWR_GAIN_BIT = 9;
  localparam int LIMIT_PIN_FN_BIT = 8;
  localparam int COMPARATOR_REFERENCE_SELECT_BIT = 7;
  localparam int COMPARATOR_POLARITY_BIT = 6;
  localparam int COMPARATOR_DEGLITCH_SELECT_HI = 5;
  localparam int COMPARATOR_DEGLITCH_SELECT_LO = 4;
  localparam int SHUTOFF_EN_BIT = 3;
  localparam int PASSTHRU_EN_BIT = 2;
  localparam int SHIP_DCHG_BIT = 1;
  localparam int AUTO_WAKE_BIT = 0;

  // Field codes
  localparam logic [1:0] ALERT_SYS_RAIL = 2'h2;
  localparam logic [1:0] DEG_OFF = 2'h0;
  localparam logic [1:0] DEG_SHORT = 2'h1;
  localparam logic [1:0] DEG_MID = 2'h2;

  // Times in their own units
  localparam longint unsigned DEG_SHORT_US = 64'd1;
  localparam longint unsigned DEG_MID_MS = 64'd2;
  localparam longint unsigned DEG_LONG_S = 64'd5;
  localparam longint unsigned SHIP_DCHG_MS = 64'd140;
  localparam longint unsigned WAKE_CHG_MIN = 64'd30;

  // Cycle counts derived from the clock rate
  localparam longint unsigned DEG_SHORT_CYC = DEG_SHORT_US * CLK_HZ / 64'd1_000_000;
  localparam longint unsigned DEG_MID_CYC = DEG_MID_MS * CLK_HZ / 64'd1_000;
  localparam longint unsigned DEG_LONG_CYC = DEG_LONG_S * CLK_HZ;
  localparam longint unsigned SHIP_DCHG_CYC = SHIP_DCHG_MS * CLK_HZ / 64'd1_000;
  localparam longint unsigned WAKE_CHG_CYC = WAKE_CHG_MIN * 64'd60 * CLK_HZ;

  // Counter widths
  localparam int DEG_CNT_W = 28;
  localparam int SHIP_CNT_W = 23;
  localparam int WAKE_CNT_W = 37;

endpackage

// >>> hw/cocr_deglitch.sv
// Comparator output filter: delays only the high-to-low edge
`timescale 1ns/100ps
`default_nettype none
module cocr_deglitch
  import cocr_pkg::*;
#(
  parameter logic [DEG_CNT_W-1:0] MID_CYC = DEG_CNT_W'(DEG_MID_CYC),
  parameter logic [DEG_CNT_W-1:0] LONG_CYC = DEG_CNT_W'(DEG_LONG_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw comparator output level and filter setup
  input wire logic rawHigh,
  input wire logic [1:0] degSel,
  // Filtered output level
  output logic filtHigh
);

  localparam logic [DEG_CNT_W-1:0] SHORT_CYC = DEG_CNT_W'(DEG_SHORT_CYC);
  localparam logic [DEG_CNT_W-1:0] ONE = DEG_CNT_W'(1);

  logic filtHigh_reg, filtHigh_next; // Filtered level
  logic [DEG_CNT_W-1:0] cnt_reg, cnt_next; // Low-time counter
  logic [DEG_CNT_W-1:0] limit; // Selected deglitch length

  // Pick the low-going deglitch length from the select code
  always_comb begin
    unique case (degSel)
      DEG_SHORT: limit = SHORT_CYC;
      DEG_MID: limit = MID_CYC;
      default: limit = LONG_CYC;
    endcase
  end

  // Rising edges pass at once, falling edges wait out the count
  always_comb begin
    filtHigh_next = filtHigh_reg;
    cnt_next = '0;
    if (degSel == DEG_OFF || rawHigh) begin
      filtHigh_next = 1'b1;
    end else if (filtHigh_reg) begin
      if (cnt_reg >= limit - ONE) begin
        filtHigh_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + ONE;
      end
    end
  end

  // Register the filter state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filtHigh_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      filtHigh_reg <= filtHigh_next;
      cnt_reg <= cnt_next;
    end
  end

  assign filtHigh = filtHigh_reg;

endmodule
`default_nettype wire

// >>> hw/cocr_charger_config.sv
// Second charger configuration register and the logic it steers
`timescale 1ns/100ps
`default_nettype none
module cocr_charger_config
  import cocr_pkg::*;
#(
  parameter logic [DEG_CNT_W-1:0] DEG_MID_CYCLES = DEG_CNT_W'(DEG_MID_CYC),
  parameter logic [DEG_CNT_W-1:0] DEG_LONG_CYCLES = DEG_CNT_W'(DEG_LONG_CYC),
  parameter logic [SHIP_CNT_W-1:0] SHIP_CYCLES = SHIP_CNT_W'(SHIP_DCHG_CYC),
  parameter logic [WAKE_CNT_W-1:0] WAKE_CYCLES = WAKE_CNT_W'(WAKE_CHG_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decoded register command port
  input wire logic [7:0] cmdAddr,
  input wire logic wrStrobe,
  input wire logic [15:0] wrData,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  output logic addrHit,
  // Low-power mode bit of the first configuration register
  input wire logic lowPowerMode,
  // Asynchronous status inputs from pins and analog
  input wire logic current_limit_highz_pin,
  input wire logic comparatorAboveThreshold,
  input wire logic batteryBelowMinSys,
  input wire logic supplyGoodRaw,
  // Monitor and sensing controls
  output logic battCurrentMonitorEn,
  output logic systemPowerMonitorEn,
  output logic lowpowerThrottleAlertEn,
  output logic inputShuntSel,
  output logic chargeShuntSel,
  output logic powerMonitorGain,
  // Comparator controls and output
  output logic comparatorReferenceSel,
  output logic comparatorEnable,
  output logic comparator_output_pin,
  // Power path controls
  output logic inputSwitchForceOff,
  output logic outputSwitchForceOff,
  output logic supply_good_output,
  output logic passThroughActive,
  output logic highImpedanceActive,
  output logic shippingDischargeActive,
  output logic autoWakeChargeEn
);

  // Three-stage input synchroniser with agreement filter
  localparam int NSYNC = 3;
  // Idle levels: supply good high, comparator below, limit pin high
  localparam logic [NSYNC-1:0] SYNC_IDLE = 3'h5;
  logic [NSYNC-1:0] asyncIn; // Raw asynchronous inputs
  logic [NSYNC-1:0] syncA_reg, syncB_reg, syncC_reg; // Sync stages
  logic [NSYNC-1:0] syncOut_reg, syncOut_next; // Accepted levels
  logic limitPinLow; // Limit pin held low
  logic cmpAbove; // Comparator input above threshold
  logic battLow; // Battery below minimum system voltage

  // Register and timers
  logic [15:0] cfg_reg, cfg_next; // Configuration register
  logic [SHIP_CNT_W-1:0] shipCnt_reg, shipCnt_next; // Discharge timer
  logic [WAKE_CNT_W-1:0] wakeCnt_reg, wakeCnt_next; // Wake charge timer
  logic wakeDone_reg, wakeDone_next; // Wake charge time used up
  logic wakeSeenLow_reg, wakeSeenLow_next; // Battery seen low, wake armed
  logic latchOff_reg, latchOff_next; // Forced shutoff latch
  logic [15:0] rdData_reg, rdData_next; // Read data register
  logic cmpRawHigh; // Unfiltered comparator output
  logic cmpFiltHigh; // Deglitched comparator output
  logic cmpTrip; // Comparator tripped
  logic hostWrite; // Host write to this register
  logic shipExpire; // Discharge time elapsed
  logic wakeEnd; // Battery recovered during wake charge

  // Decode a command address against this register
  function automatic logic isCfgAddr(input logic [7:0] addr);
    isCfgAddr = (addr == CFG2_ADDR);
  endfunction

  assign asyncIn = {supplyGoodRaw, comparatorAboveThreshold,
                    current_limit_highz_pin};

  // Accept a new input level once stages two and three agree
  always_comb begin
    syncOut_next = syncOut_reg;
    for (int i = 0; i < NSYNC; i++) begin
      if (syncB_reg[i] == syncC_reg[i]) begin
        syncOut_next[i] = syncC_reg[i];
      end
    end
  end

  // Synchroniser flops, batteryBelowMinSys handled below
  // Stages reset to the idle levels, so release shows no false edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_reg <= SYNC_IDLE;
      syncB_reg <= SYNC_IDLE;
      syncC_reg <= SYNC_IDLE;
      syncOut_reg <= SYNC_IDLE;
    end else begin
      syncA_reg <= asyncIn;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      syncOut_reg <= syncOut_next;
    end
  end

  // Separate synchroniser for the battery level input
  logic battA_reg, battB_reg, battC_reg, battOut_reg, battOut_next;

  // Accept the battery level when stages two and three agree
  always_comb begin
    battOut_next = (battB_reg == battC_reg) ? battC_reg : battOut_reg;
  end

  // Battery level synchroniser flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      battA_reg <= 1'b0;
      battB_reg <= 1'b0;
      battC_reg <= 1'b0;
      battOut_reg <= 1'b0;
    end else begin
      battA_reg <= batteryBelowMinSys;
      battB_reg <= battA_reg;
      battC_reg <= battB_reg;
      battOut_reg <= battOut_next;
    end
  end

  assign limitPinLow = ~syncOut_reg[0];
  assign cmpAbove = syncOut_reg[1];
  assign battLow = battOut_reg;

  // Comparator raw output level per polarity
  always_comb begin
    if (cfg_reg[COMPARATOR_POLARITY_BIT]) begin
      cmpRawHigh = cmpAbove; // low when below threshold
    end else begin
      cmpRawHigh = ~cmpAbove; // low when above threshold
    end
  end

  // Falling-edge deglitch of the comparator output
  cocr_deglitch #(
    .MID_CYC(DEG_MID_CYCLES),
    .LONG_CYC(DEG_LONG_CYCLES)
  ) u_deglitch (
    .clk(clk),
    .rst_n(rst_n),
    .rawHigh(cmpRawHigh),
    .degSel(cfg_reg[COMPARATOR_DEGLITCH_SELECT_HI:COMPARATOR_DEGLITCH_SELECT_LO]),
    .filtHigh(cmpFiltHigh)
  );

  // A disabled comparator never trips
  assign cmpTrip = comparatorEnable & ~cmpFiltHigh;

  // Host write to this register; discharge ends after its full count
  assign hostWrite = wrStrobe & isCfgAddr(cmdAddr);
  assign shipExpire = cfg_reg[SHIP_DCHG_BIT] &&
                      (shipCnt_reg >= SHIP_CYCLES - SHIP_CNT_W'(1));
  // Battery recovered after it was seen low with the wake bit armed
  assign wakeEnd = cfg_reg[AUTO_WAKE_BIT] & ~battLow & wakeSeenLow_reg;

  // Register next value: host writes win over hardware clears
  always_comb begin
    cfg_next = cfg_reg;
    if (shipExpire) begin
      cfg_next[SHIP_DCHG_BIT] = 1'b0;
    end
    if (wakeEnd) begin
      cfg_next[AUTO_WAKE_BIT] = 1'b0;
    end
    if (hostWrite) begin
      cfg_next = wrData; // all codes stored
    end
  end

  // Shipping discharge and wake charge timers
  always_comb begin
    shipCnt_next = '0;
    wakeCnt_next = wakeCnt_reg;
    wakeDone_next = wakeDone_reg;
    if (cfg_reg[SHIP_DCHG_BIT] && !shipExpire) begin
      shipCnt_next = shipCnt_reg + SHIP_CNT_W'(1);
    end
    if (!cfg_reg[AUTO_WAKE_BIT] || !battLow) begin
      wakeCnt_next = '0;
      wakeDone_next = 1'b0;
    end else if (!wakeDone_reg) begin
      if (wakeCnt_reg >= WAKE_CYCLES - WAKE_CNT_W'(1)) begin
        wakeDone_next = 1'b1; // charge limited in time
      end else begin
        wakeCnt_next = wakeCnt_reg + WAKE_CNT_W'(1);
      end
    end
  end

  // Remember that the battery was low while wake charge was armed
  always_comb begin
    wakeSeenLow_next = 1'b0;
    if (cfg_reg[AUTO_WAKE_BIT] && battLow) begin
      wakeSeenLow_next = 1'b1;
    end
  end

  // Forced shutoff latch, released when the host clears the enable
  always_comb begin
    latchOff_next = latchOff_reg;
    if (!cfg_reg[SHUTOFF_EN_BIT]) begin
      latchOff_next = 1'b0;
    end
    if (cfg_reg[SHUTOFF_EN_BIT] && cmpTrip) begin
      latchOff_next = 1'b1;
    end
  end

  // Read data: register on a hit, zero for other addresses
  always_comb begin
    rdData_next = rdData_reg;
    if (rdStrobe) begin
      rdData_next = isCfgAddr(cmdAddr) ? cfg_reg : 16'h0000;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= CFG2_RESET;
      shipCnt_reg <= '0;
      wakeCnt_reg <= '0;
      wakeDone_reg <= 1'b0;
      wakeSeenLow_reg <= 1'b0;
      latchOff_reg <= 1'b0;
      rdData_reg <= 16'h0000;
    end else begin
      cfg_reg <= cfg_next;
      shipCnt_reg <= shipCnt_next;
      wakeCnt_reg <= wakeCnt_next;
      wakeDone_reg <= wakeDone_next;
      wakeSeenLow_reg <= wakeSeenLow_next;
      latchOff_reg <= latchOff_next;
      rdData_reg <= rdData_next;
    end
  end

  // Register port outputs
  assign rdData = rdData_reg;
  assign addrHit = isCfgAddr(cmdAddr) & (rdStrobe | wrStrobe);

  // Monitor controls; only the two monitor enables gated by low-power mode
  assign battCurrentMonitorEn = cfg_reg[BATT_MON_EN_BIT] & ~lowPowerMode;
  assign systemPowerMonitorEn = cfg_reg[SYS_PWR_EN_BIT] & ~lowPowerMode;
  assign lowpowerThrottleAlertEn =
    (cfg_reg[ALERT_SEL_HI:ALERT_SEL_LO] == ALERT_SYS_RAIL);
  assign inputShuntSel = cfg_reg[IN_SHUNT_BIT];
  assign chargeShuntSel = cfg_reg[CHG_SHUNT_BIT];
  assign powerMonitorGain = cfg_reg[PWR_GAIN_BIT];

  // Comparator controls
  assign comparatorReferenceSel = cfg_reg[COMPARATOR_REFERENCE_SELECT_BIT];
  assign comparatorEnable = (cfg_reg[COMPARATOR_DEGLITCH_SELECT_HI:COMPARATOR_DEGLITCH_SELECT_LO] != DEG_OFF);
  assign comparator_output_pin = cmpFiltHigh;

  // Power path: shutoff latch and limit pin function
  assign inputSwitchForceOff = latchOff_reg;
  assign outputSwitchForceOff = latchOff_reg;
  assign supply_good_output = syncOut_reg[2] & ~latchOff_reg;
  assign passThroughActive = cfg_reg[PASSTHRU_EN_BIT] |
    (limitPinLow & cfg_reg[LIMIT_PIN_FN_BIT]);
  assign highImpedanceActive = limitPinLow & ~cfg_reg[LIMIT_PIN_FN_BIT];

  // Shipping discharge and wake charge
  assign shippingDischargeActive = cfg_reg[SHIP_DCHG_BIT];
  assign autoWakeChargeEn = cfg_reg[AUTO_WAKE_BIT] & battLow &
                            ~wakeDone_reg;

endmodule
`default_nettype wire

// >>> verif/cocr_monitor.sv
// Checker: port-level properties of the second charger config register
`timescale 1ns/100ps
`default_nettype none
module cocr_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register command port
  input wire logic [7:0] cmdAddr,
  input wire logic wrStrobe,
  input wire logic [15:0] wrData,
  input wire logic rdStrobe,
  input wire logic [15:0] rdData,
  input wire logic addrHit,
  // Controls and status
  input wire logic lowPowerMode,
  input wire logic battCurrentMonitorEn,
  input wire logic systemPowerMonitorEn,
  input wire logic lowpowerThrottleAlertEn,
  input wire logic comparatorEnable,
  input wire logic comparator_output_pin,
  input wire logic inputSwitchForceOff,
  input wire logic outputSwitchForceOff,
  input wire logic supply_good_output,
  input wire logic shippingDischargeActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Host write aimed at this register
  logic wrHit;
  assign wrHit = wrStrobe && cmdAddr == 8'h30;
  a_hit_decode: assert property (
    addrHit == (cmdAddr == 8'h30 && (wrStrobe || rdStrobe)))
    else $error("address hit decode wrong");
  a_read_other: assert property (
    rdStrobe && cmdAddr != 8'h30 |=> rdData == 16'h0000)
    else $error("unmapped read not zero");
  a_batt_gate: assert property (
    wrHit |=> battCurrentMonitorEn == ($past(wrData[15]) && !lowPowerMode))
    else $error("battery monitor enable wrong");
  a_sys_gate: assert property (
    lowPowerMode |-> !systemPowerMonitorEn)
    else $error("system power monitor on in low power");
  a_alert_code: assert property (
    wrHit |=> lowpowerThrottleAlertEn == ($past(wrData[14:13]) == 2'h2))
    else $error("alert enable decode wrong");
  a_cmp_idle: assert property (
    !comparatorEnable [*3] |-> comparator_output_pin)
    else $error("disabled comparator output not high");
  a_shutoff_path: assert property (
    $rose(inputSwitchForceOff) |->
      outputSwitchForceOff ##[0:2] !supply_good_output)
    else $error("shutoff did not open path");
  a_ship_clears: assert property (
    $rose(shippingDischargeActive) |->
      shippingDischargeActive [*8] ##[1:40] !shippingDischargeActive)
    else $error("shipping discharge length wrong");
endmodule
bind cocr_charger_config cocr_monitor cocr_monitor_inst (.*);
`default_nettype wire

// >>> verif/cocr_host_model.sv
// Host controller model driving the register command port
`timescale 1ns/100ps
`default_nettype none
module cocr_host_model (
  // Clock
  input wire logic clk,
  // Command port toward the register
  output logic [7:0] cmdAddr,
  output logic wrStrobe,
  output logic [15:0] wrData,
  output logic rdStrobe,
  input wire logic [15:0] rdData
);
  // Idle port at time zero
  initial begin
    cmdAddr = 8'h00;
    wrStrobe = 1'b0;
    wrData = 16'h0000;
    rdStrobe = 1'b0;
  end
  // One write; strobe held high for one clock cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    cmdAddr = a;
    wrData = d;
    wrStrobe = 1'b1;
    @(negedge clk);
    wrStrobe = 1'b0;
    wrData = ~d; // Stale data must not look valid
  endtask
  // One read; data is registered at the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    cmdAddr = a;
    rdStrobe = 1'b1;
    @(negedge clk);
    rdStrobe = 1'b0;
    d = rdData;
  endtask
endmodule
`default_nettype wire

// >>> verif/cocr_charger_config_bench.sv
// Testbench for the second charger configuration register
`timescale 1ns/100ps
`default_nettype none
module cocr_charger_config_bench;
  // Clock, reset and counters
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  // Design ports
  logic [7:0] cmdAddr;
  logic [15:0] wrData, rdData, rv;
  logic wrStrobe, rdStrobe, addrHit, lowPowerMode, current_limit_highz_pin;
  logic comparatorAboveThreshold, batteryBelowMinSys, supplyGoodRaw;
  logic battCurrentMonitorEn, systemPowerMonitorEn, lowpowerThrottleAlertEn;
  logic inputShuntSel, chargeShuntSel, powerMonitorGain, comparatorEnable;
  logic comparatorReferenceSel, comparator_output_pin, inputSwitchForceOff;
  logic outputSwitchForceOff, supply_good_output, passThroughActive;
  logic highImpedanceActive, shippingDischargeActive, autoWakeChargeEn;
  always #12.5 clk = ~clk;
  // Design with shortened counts
  cocr_charger_config #(.DEG_MID_CYCLES(28'd20), .DEG_LONG_CYCLES(28'd50),
    .SHIP_CYCLES(23'd30), .WAKE_CYCLES(37'd40)) cocr_charger_config_inst (
    .clk, .rst_n, .cmdAddr, .wrStrobe, .wrData, .rdStrobe, .rdData, .addrHit,
    .lowPowerMode, .current_limit_highz_pin, .comparatorAboveThreshold,
    .batteryBelowMinSys, .supplyGoodRaw, .battCurrentMonitorEn,
    .systemPowerMonitorEn, .lowpowerThrottleAlertEn, .inputShuntSel,
    .chargeShuntSel, .powerMonitorGain, .comparatorReferenceSel,
    .comparatorEnable, .comparator_output_pin, .inputSwitchForceOff,
    .outputSwitchForceOff, .supply_good_output, .passThroughActive,
    .highImpedanceActive, .shippingDischargeActive, .autoWakeChargeEn);
  // Host side of the command port
  cocr_host_model cocr_host_model_inst (.clk, .cmdAddr, .wrStrobe, .wrData,
    .rdStrobe, .rdData);
  // Compare one value, report a mismatch at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write and checked read
  task automatic wreg(input logic [15:0] d);
    cocr_host_model_inst.wr(8'h30, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    cocr_host_model_inst.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #(5000 * 25);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    lowPowerMode = 1'b0;
    current_limit_highz_pin = 1'b1;
    comparatorAboveThreshold = 1'b0;
    batteryBelowMinSys = 1'b0;
    supplyGoodRaw = 1'b1;
    idle(3);
    rst_n = 1'b1;
    rchk(8'h30, 16'h0211);
    chk(powerMonitorGain, 1'b1);
    chk(comparatorReferenceSel, 1'b0);
    cocr_host_model_inst.wr(8'h31, 16'hFFFF);
    rchk(8'h31, 16'h0000);
    rchk(8'h30, 16'h0211);
    $display("Test reset and decode done");
    // Every alert code with shunt and reference fields
    for (int i = 0; i < 4; i++) begin
      wreg(16'(i) << 13 | 16'(i) << 10 | 16'h0080);
      chk(lowpowerThrottleAlertEn, 16'(i == 2));
      chk(inputShuntSel, 16'(i[1]));
      chk(chargeShuntSel, 16'(i[0]));
      chk(powerMonitorGain, 1'b0);
      chk(comparatorReferenceSel, 1'b1);
      chk(comparatorEnable, 1'b0);
      rchk(8'h30, 16'(i) << 13 | 16'(i) << 10 | 16'h0080);
    end
    chk(comparator_output_pin, 1'b1);
    $display("Test field decode done");
    wreg(16'h9000);
    chk(battCurrentMonitorEn, 1'b1);
    chk(systemPowerMonitorEn, 1'b1);
    lowPowerMode = 1'b1;
    idle(1);
    chk(battCurrentMonitorEn, 1'b0);
    chk(systemPowerMonitorEn, 1'b0);
    lowPowerMode = 1'b0;
    $display("Test low power gating done");
    wreg(16'h0000);
    current_limit_highz_pin = 1'b0;
    idle(6);
    chk(highImpedanceActive, 1'b1);
    chk(passThroughActive, 1'b0);
    wreg(16'h0100);
    chk(passThroughActive, 1'b1);
    chk(highImpedanceActive, 1'b0);
    current_limit_highz_pin = 1'b1;
    idle(6);
    chk(passThroughActive, 1'b0);
    wreg(16'h0004);
    chk(passThroughActive, 1'b1);
    $display("Test pin function done");
    wreg(16'h0002);
    chk(shippingDischargeActive, 1'b1);
    rchk(8'h30, 16'h0002);
    idle(22);
    chk(shippingDischargeActive, 1'b1);
    idle(10);
    rchk(8'h30, 16'h0000);
    $display("Test shipping discharge done");
    wreg(16'h0018);
    chk(comparatorEnable, 1'b1);
    comparatorAboveThreshold = 1'b1;
    idle(25);
    chk(comparator_output_pin, 1'b1);
    chk(inputSwitchForceOff, 1'b0);
    idle(30);
    chk(comparator_output_pin, 1'b0);
    chk(outputSwitchForceOff, 1'b1);
    chk(supply_good_output, 1'b0);
    comparatorAboveThreshold = 1'b0;
    idle(7);
    chk(comparator_output_pin, 1'b1);
    chk(inputSwitchForceOff, 1'b1);
    wreg(16'h0010);
    idle(2);
    chk(inputSwitchForceOff, 1'b0);
    chk(supply_good_output, 1'b1);
    wreg(16'h0070);
    idle(40);
    chk(comparator_output_pin, 1'b1);
    idle(20);
    chk(comparator_output_pin, 1'b0);
    wreg(16'h0020);
    idle(7);
    comparatorAboveThreshold = 1'b1;
    idle(16);
    chk(comparator_output_pin, 1'b1);
    idle(14);
    chk(comparator_output_pin, 1'b0);
    $display("Test comparator done");
    wreg(16'h0001);
    batteryBelowMinSys = 1'b1;
    idle(6);
    chk(autoWakeChargeEn, 1'b1);
    idle(44);
    chk(autoWakeChargeEn, 1'b0);
    batteryBelowMinSys = 1'b0;
    idle(6);
    rchk(8'h30, 16'h0000);
    $display("Test wake charge done");
    complete_run();
  end
endmodule
`default_nettype wire
